// >>> shared/pci_defs.svh
// Register map, field positions, reset values and sizes of the pin change interrupt unit.
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH

// Data-space byte offsets.
`define PCI_ADDR_FLAGS 8'h3b
`define PCI_ADDR_EXT_FLAGS 8'h3c
`define PCI_ADDR_EXT_MASK 8'h3d
`define PCI_ADDR_BANK_EN 8'h68
`define PCI_ADDR_SENSE 8'h69
`define PCI_ADDR_MASK0 8'h6b
`define PCI_ADDR_MASK1 8'h6c
`define PCI_ADDR_MASK2 8'h6d
`define PCI_ADDR_MASK3 8'h73

// I/O instructions address data space less this base.
`define PCI_IO_BASE 8'h20

// Implemented bits of each register.
`define PCI_IMPL_MASK0 8'hff
`define PCI_IMPL_MASK1 8'h7f
`define PCI_IMPL_MASK2 8'hff
`define PCI_IMPL_MASK3 8'h0f
`define PCI_BANK_BITS 4
`define PCI_EXT0_BIT 0

// Reset values.
`define PCI_RESET_BYTE 8'h00
`define PCI_RESET_BANK 4'h0
`define PCI_RESET_SENSE 2'h0

// Vector request positions on the request bus.
`define PCI_VEC_EXT0 0
`define PCI_VEC_BANK0 1
`define PCI_NUM_VEC 5

`endif

// >>> shared/pci_pkg.sv
// Types shared by the pin change interrupt unit.
package pci_pkg;

  // Sense codes for external pin 0.
  typedef enum logic [1:0] {
    PCI_SENSE_LOW = 2'b00,
    PCI_SENSE_ANY = 2'b01,
    PCI_SENSE_FALL = 2'b10,
    PCI_SENSE_RISE = 2'b11
  } pci_sense_e;

  // Data-space load/store access from the core.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pci_data_req_s;

  // I/O-instruction access from the core.
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pci_io_req_s;

endpackage : pci_pkg

// >>> verilog/pci_unit.sv
// Pin change and external pin 0 interrupt unit with its register file.
`timescale 1ns/10ps
`default_nettype none
`include "pci_defs.svh"

// One group of asynchronous pins: three flops, an agree filter and the previous settled sample.
// Keeping the chain in one place means the pin banks and external pin 0 age identically.
module pci_pin_watch
  import pci_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic primed_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] prev_out
);

  // Stage 1 is read only by stage 2, so a metastable value never reaches the filter.
  logic [WIDTH-1:0] sync1_ff;
  logic [WIDTH-1:0] sync2_ff;
  logic [WIDTH-1:0] sync3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] nxt_level;

  // A new level counts once stages 2 and 3 agree; a one-cycle glitch is dropped.
  assign agree = ~(sync2_ff ^ sync3_ff);
  assign nxt_level = (agree & sync3_ff) | (~agree & level_ff);

  // Synchroniser chain.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Until the chain is primed the previous sample follows the level, so the reset value of
  // the flops never shows up as a change when a pin idles high.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_ff <= '0;
      prev_ff <= '0;
    end else begin
      level_ff <= nxt_level;
      prev_ff <= primed_in ? level_ff : nxt_level;
    end
  end

  assign level_out = level_ff;
  assign prev_out = prev_ff;

endmodule : pci_pin_watch

// A group of request flags that hardware sets and software or the core clears.
module pci_flag_cell
  import pci_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic hold_clear_in,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] next_out,
  output logic [WIDTH-1:0] flag_out
);

  logic [WIDTH-1:0] flag_ff;
  logic [WIDTH-1:0] nxt_flag;

  // A set in the same cycle as a clear wins, so no change is lost to a late clear.
  assign nxt_flag = hold_clear_in ? '0 : ((flag_ff & ~clear_in) | set_in);

  // Flag storage.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign next_out = nxt_flag;
  assign flag_out = flag_ff;

endmodule : pci_flag_cell

module pci_unit
  import pci_pkg::*;
#(
  parameter int PIN_COUNT = 28,
  parameter int SYNC_STAGES = 3
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [PIN_COUNT-1:0] change_input_pin_in,
  input wire logic ext_irq0_pin_in,
  input wire logic global_irq_enable_in,
  input wire pci_data_req_s data_req_in,
  input wire pci_io_req_s io_req_in,
  input wire logic [`PCI_NUM_VEC-1:0] vector_ack_in,
  output logic [7:0] rdata_out,
  output logic [`PCI_NUM_VEC-1:0] vector_req_out
);

  // Settled pin levels and their previous samples from the synchronisers.
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_prev;
  logic ext_level;
  logic ext_prev;

  // Software-visible registers; the flags live in their flag cells.
  logic [`PCI_BANK_BITS-1:0] bank_en_ff;
  logic [`PCI_BANK_BITS-1:0] bank_flags;
  logic [7:0] mask_ff [`PCI_BANK_BITS];
  logic ext_mask_ff;
  logic ext_flag;
  pci_sense_e sense_ff;

  // Registered outputs.
  logic [7:0] rdata_ff;
  logic [`PCI_NUM_VEC-1:0] vector_req_ff;

  // Unified register access: data space wins when both ports strike together.
  logic data_acc;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic acc_wr;
  logic acc_rd;
  assign data_acc = data_req_in.wr | data_req_in.rd;
  // I/O addresses map to 0x20..0x5f, so extended space stays out of reach.
  assign acc_addr = data_acc ? data_req_in.addr : ({2'b00, io_req_in.addr} + `PCI_IO_BASE);
  assign acc_wdata = data_acc ? data_req_in.wdata : io_req_in.wdata;
  assign acc_wr = data_acc ? data_req_in.wr : io_req_in.wr;
  assign acc_rd = data_acc ? data_req_in.rd : io_req_in.rd;

  // Address decode.
  logic hit_flags;
  logic hit_ext_flags;
  logic hit_ext_mask;
  logic hit_bank_en;
  logic hit_sense;
  logic [`PCI_BANK_BITS-1:0] hit_mask;
  assign hit_flags = acc_addr == `PCI_ADDR_FLAGS;
  assign hit_ext_flags = acc_addr == `PCI_ADDR_EXT_FLAGS;
  assign hit_ext_mask = acc_addr == `PCI_ADDR_EXT_MASK;
  assign hit_bank_en = acc_addr == `PCI_ADDR_BANK_EN;
  assign hit_sense = acc_addr == `PCI_ADDR_SENSE;
  assign hit_mask[0] = acc_addr == `PCI_ADDR_MASK0;
  assign hit_mask[1] = acc_addr == `PCI_ADDR_MASK1;
  assign hit_mask[2] = acc_addr == `PCI_ADDR_MASK2;
  assign hit_mask[3] = acc_addr == `PCI_ADDR_MASK3;

  // Implemented bits per mask register; the rest store nothing and read zero.
  logic [7:0] impl_mask [`PCI_BANK_BITS];
  assign impl_mask[0] = `PCI_IMPL_MASK0;
  assign impl_mask[1] = `PCI_IMPL_MASK1;
  assign impl_mask[2] = `PCI_IMPL_MASK2;
  assign impl_mask[3] = `PCI_IMPL_MASK3;

  // Read multiplexer; an unmapped address reads as zero.
  logic [7:0] rd_mux;
  assign rd_mux = hit_flags ? {4'h0, bank_flags} :
                  hit_ext_flags ? {7'h00, ext_flag} :
                  hit_ext_mask ? {7'h00, ext_mask_ff} :
                  hit_bank_en ? {4'h0, bank_en_ff} :
                  hit_sense ? {6'h00, sense_ff} :
                  hit_mask[0] ? mask_ff[0] :
                  hit_mask[1] ? mask_ff[1] :
                  hit_mask[2] ? mask_ff[2] :
                  hit_mask[3] ? mask_ff[3] : `PCI_RESET_BYTE;

  // Edges counted since reset; the chains hold a real pin sample only after this many.
  // The counter is three bits wide, which limits SYNC_STAGES to six.
  localparam int PRIME_CYCLES = SYNC_STAGES + 1;
  logic [2:0] prime_cnt_ff;
  logic primed;
  assign primed = prime_cnt_ff == 3'(PRIME_CYCLES);
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prime_cnt_ff <= 3'h0;
    end else if (!primed) begin
      prime_cnt_ff <= prime_cnt_ff + 3'h1;
    end
  end

  // Pin banks and external pin 0 pass the same three-flop agree filter.
  pci_pin_watch #(
    .WIDTH(PIN_COUNT)
  ) u_pin_watch (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .primed_in(primed),
    .pin_in(change_input_pin_in),
    .level_out(pin_level),
    .prev_out(pin_prev)
  );
  pci_pin_watch #(
    .WIDTH(1)
  ) u_ext_watch (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .primed_in(primed),
    .pin_in(ext_irq0_pin_in),
    .level_out(ext_level),
    .prev_out(ext_prev)
  );

  // Change is a difference between two consecutive settled samples.
  logic [31:0] pin_change;
  assign pin_change = {{(32 - PIN_COUNT){1'b0}}, pin_level ^ pin_prev};

  // Bank hits: unmasked pin change qualified by its bank enable.
  logic [`PCI_BANK_BITS-1:0] bank_hit;
  genvar gb;
  generate
    for (gb = 0; gb < `PCI_BANK_BITS; gb++) begin : g_bank
      // Bank 0..3 cover pins 7..0, 14..8, 23..16 and 27..24.
      assign bank_hit[gb] = bank_en_ff[gb] & (|(pin_change[gb*8 +: 8] & mask_ff[gb]));
    end
  endgenerate

  // Software clears of bank flags; only set bits clear.
  logic [`PCI_BANK_BITS-1:0] flag_w1c;
  logic [`PCI_BANK_BITS-1:0] flag_ack;
  logic [`PCI_BANK_BITS-1:0] nxt_flags;
  assign flag_w1c = (acc_wr & hit_flags) ? acc_wdata[`PCI_BANK_BITS-1:0] : '0;
  assign flag_ack = vector_ack_in[`PCI_VEC_BANK0 +: `PCI_BANK_BITS];

  // Bank flags: a qualified change sets, a one-write or the core's ack clears.
  pci_flag_cell #(
    .WIDTH(`PCI_BANK_BITS)
  ) u_bank_flags (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .hold_clear_in(1'b0),
    .set_in(bank_hit),
    .clear_in(flag_w1c | flag_ack),
    .next_out(nxt_flags),
    .flag_out(bank_flags)
  );

  // External pin 0 edge selection by sense code.
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic ext_level_mode;
  assign ext_rise = ext_level & ~ext_prev;
  assign ext_fall = ~ext_level & ext_prev;
  assign ext_level_mode = sense_ff == PCI_SENSE_LOW;
  assign ext_edge = (sense_ff == PCI_SENSE_ANY) ? (ext_rise | ext_fall) :
                    (sense_ff == PCI_SENSE_FALL) ? ext_fall :
                    (sense_ff == PCI_SENSE_RISE) ? ext_rise : 1'b0;

  // External pin 0 flag: level mode holds it clear, else set beats clear.
  logic ext_clr;
  logic nxt_ext_flag;
  assign ext_clr = (acc_wr & hit_ext_flags & acc_wdata[`PCI_EXT0_BIT])
                   | vector_ack_in[`PCI_VEC_EXT0];
  pci_flag_cell #(
    .WIDTH(1)
  ) u_ext_flag (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .hold_clear_in(ext_level_mode),
    .set_in(ext_edge),
    .clear_in(ext_clr),
    .next_out(nxt_ext_flag),
    .flag_out(ext_flag)
  );

  // Vector requests: flag, its enable and the core's global enable.
  logic ext_cause;
  logic [`PCI_NUM_VEC-1:0] nxt_vector_req;
  // In level mode the low pin itself requests, without a flag, once the chain is primed.
  assign ext_cause = ext_level_mode ? (primed & ~ext_level) : nxt_ext_flag;
  assign nxt_vector_req[`PCI_VEC_EXT0] = global_irq_enable_in & ext_mask_ff & ext_cause;
  assign nxt_vector_req[`PCI_VEC_BANK0 +: `PCI_BANK_BITS] =
    {`PCI_BANK_BITS{global_irq_enable_in}} & bank_en_ff & nxt_flags;

  // Requests are registered from the next flag value, so they appear with the flag.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vector_req_ff <= '0;
    end else begin
      vector_req_ff <= nxt_vector_req;
    end
  end

  // Write strobes of the control registers.
  logic wr_bank_en;
  logic wr_ext_mask;
  logic wr_sense;
  assign wr_bank_en = acc_wr & hit_bank_en;
  assign wr_ext_mask = acc_wr & hit_ext_mask;
  assign wr_sense = acc_wr & hit_sense;

  // Bank enables; only the low nibble exists.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bank_en_ff <= `PCI_RESET_BANK;
    end else if (wr_bank_en) begin
      bank_en_ff <= acc_wdata[`PCI_BANK_BITS-1:0];
    end
  end

  // External pin 0 mask bit.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_mask_ff <= 1'b0;
    end else if (wr_ext_mask) begin
      ext_mask_ff <= acc_wdata[`PCI_EXT0_BIT];
    end
  end

  // Sense select; reset leaves external pin 0 in low-level mode, which keeps its flag clear.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sense_ff <= PCI_SENSE_LOW;
    end else if (wr_sense) begin
      sense_ff <= pci_sense_e'(acc_wdata[1:0]);
    end
  end

  // Per-pin mask registers keep only implemented bits.
  genvar gm;
  generate
    for (gm = 0; gm < `PCI_BANK_BITS; gm++) begin : g_mask
      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          mask_ff[gm] <= `PCI_RESET_BYTE;
        end else if (acc_wr & hit_mask[gm]) begin
          mask_ff[gm] <= acc_wdata & impl_mask[gm];
        end
      end
    end
  endgenerate

  // Read data is captured on the edge that samples the read strobe and held until the next read.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff <= `PCI_RESET_BYTE;
    end else if (acc_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  assign rdata_out = rdata_ff;
  assign vector_req_out = vector_req_ff;

endmodule : pci_unit
`default_nettype wire

// >>> dv/pci_core_model.sv
// Core-side model that starts interrupt routines for requested vectors.
`timescale 1ns/10ps
`default_nettype none
module pci_core_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ack_en_in,
  input wire logic [4:0] vector_req_in,
  output logic [4:0] vector_ack_out
);
  // The routine starts on the lowest pending vector only, with one idle cycle between acks.
  // That gap keeps a request that is still falling from being acked twice.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vector_ack_out <= 5'h00;
    end else begin
      vector_ack_out <= (ack_en_in && vector_ack_out == 5'h00) ?
        vector_req_in & (~vector_req_in + 5'h01) : 5'h00;
    end
  end
endmodule : pci_core_model
`default_nettype wire

// >>> dv/pci_unit_assertions.sv
// Port-level assertions for the pin change interrupt unit.
`timescale 1ns/10ps
`default_nettype none
`include "pci_defs.svh"
module pci_unit_chk
  import pci_pkg::*;
#(
  parameter int PIN_COUNT = 28,
  parameter int SYNC_STAGES = 3
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [PIN_COUNT-1:0] change_input_pin_in,
  input wire logic ext_irq0_pin_in,
  input wire logic global_irq_enable_in,
  input wire pci_data_req_s data_req_in,
  input wire pci_io_req_s io_req_in,
  input wire logic [`PCI_NUM_VEC-1:0] vector_ack_in,
  input wire logic [7:0] rdata_out,
  input wire logic [`PCI_NUM_VEC-1:0] vector_req_out
);
  logic [PIN_COUNT-1:0] pin_q_ff;
  logic [2:0] quiet_ff;
  // Read strobes and flag clear bits; the data path wins over the I/O path.
  wire logic dr = data_req_in.rd;
  wire logic dsel = data_req_in.rd | data_req_in.wr;
  wire logic ir = io_req_in.rd & ~dsel;
  wire logic [3:0] clr = (data_req_in.wr && data_req_in.addr == 8'h3b) ? data_req_in.wdata[3:0] :
    (!dsel && io_req_in.wr && io_req_in.addr == 6'h1b) ? io_req_in.wdata[3:0] : 4'h0;
  // Clears are judged only after quiet pins, since a fresh change may win over them.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_q_ff <= '0;
      quiet_ff <= 3'h0;
    end else begin
      pin_q_ff <= change_input_pin_in;
      quiet_ff <= (pin_q_ff != change_input_pin_in) ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h7};
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_reset_quiet: assert property ($past(rst_in) |-> vector_req_out == '0 && rdata_out == 8'h00)
    else $error("outputs not clear after reset");
  a_req_global: assert property (vector_req_out != '0 |-> $past(global_irq_enable_in))
    else $error("vector request without global enable");
  a_io_unreach: assert property (ir && !(io_req_in.addr inside {6'h1b, 6'h1c, 6'h1d})
    |=> rdata_out == 8'h00)
    else $error("io read reached a data-only place");
  a_bank1_top: assert property (dr && data_req_in.addr == 8'h6c |=> !rdata_out[7])
    else $error("unused mask bit reads one");
  a_upper_zero: assert property (dr && data_req_in.addr inside {8'h3b, 8'h68, 8'h73}
    |=> rdata_out[7:4] == 4'h0)
    else $error("unused upper bits read nonzero");
  a_ack_clears: assert property (quiet_ff > 3'h5 && vector_ack_in[4:1] != 4'h0
    |=> (vector_req_out[4:1] & $past(vector_ack_in[4:1])) == 4'h0)
    else $error("acked request still standing");
  a_w1c_clears: assert property (quiet_ff > 3'h5 && clr != 4'h0
    |=> (vector_req_out[4:1] & $past(clr)) == 4'h0)
    else $error("cleared request still standing");
  a_read_holds: assert property (!dr && !io_req_in.rd |=> $stable(rdata_out))
    else $error("read data changed without a read");
  c_bank0: cover property (vector_req_out[1]);
  c_ext0: cover property (vector_req_out[0]);
  c_ack: cover property (vector_ack_in != '0);
endmodule : pci_unit_chk
bind pci_unit pci_unit_chk #(.PIN_COUNT(PIN_COUNT), .SYNC_STAGES(SYNC_STAGES)) u_chk (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .change_input_pin_in(change_input_pin_in),
  .ext_irq0_pin_in(ext_irq0_pin_in),
  .global_irq_enable_in(global_irq_enable_in),
  .data_req_in(data_req_in),
  .io_req_in(io_req_in),
  .vector_ack_in(vector_ack_in),
  .rdata_out(rdata_out),
  .vector_req_out(vector_req_out)
);
`default_nettype wire

// >>> dv/pci_unit_tb.sv
// Self-checking testbench for the pin change interrupt unit.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import pci_pkg::*;
;
  logic clk, rst, ext0, glob, ack_en;
  logic [27:0] pins;
  pci_data_req_s dreq;
  pci_io_req_s ioreq;
  wire logic [4:0] ack, vreq;
  wire logic [7:0] rdata;
  int fail_count = 0;
  int checks = 0;
  localparam logic [7:0] RA [5] = '{8'h68, 8'h6b, 8'h6c, 8'h6d, 8'h73};
  localparam logic [7:0] RV [5] = '{8'h0f, 8'hff, 8'h7f, 8'hff, 8'h0f};
  localparam logic [7:0] MV [4] = '{8'h01, 8'h40, 8'h01, 8'h08};
  localparam int PI [4] = '{0, 14, 16, 27};
  pci_unit DUT (.sys_clk_in(clk), .rst_in(rst), .change_input_pin_in(pins),
    .ext_irq0_pin_in(ext0), .global_irq_enable_in(glob), .data_req_in(dreq),
    .io_req_in(ioreq), .vector_ack_in(ack), .rdata_out(rdata), .vector_req_out(vreq));
  pci_core_model u_core (.sys_clk_in(clk), .rst_in(rst), .ack_en_in(ack_en),
    .vector_req_in(vreq), .vector_ack_out(ack));
  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One byte access; the request is held across exactly one rising edge.
  task automatic acc(input logic io, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    if (io) ioreq = '{a[5:0], d, w, !w};
    else dreq = '{a, d, w, !w};
    @(negedge clk);
    dreq = '0;
    ioreq = '0;
    @(negedge clk);
  endtask : acc
  task automatic rdc(input logic io, input logic [7:0] a, input logic [7:0] e);
    acc(io, 1'b0, a, 8'h00);
    chk(rdata, e);
  endtask : rdc
  task automatic wreq(input int k);
    int n;
    n = 0;
    while (vreq[k] !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    if (n == 12) begin
      fail_count++;
      final_report();
    end
  endtask : wreq
  task automatic t_regs();
    foreach (RA[i]) rdc(0, RA[i], 8'h00);
    rdc(0, 8'h3b, 8'h00);
    foreach (RA[i]) begin
      acc(0, 1, RA[i], 8'hff);
      rdc(0, RA[i], RV[i]);
    end
    acc(1, 1, 8'h48, 8'h00);
    rdc(0, 8'h68, 8'h0f);
    rdc(1, 8'h48, 8'h00);
    $display("register test done");
  endtask : t_regs
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      acc(0, 1, RA[b+1], MV[b]);
      pins[PI[b]] = ~pins[PI[b]];
      wreq(b + 1);
      rdc(0, 8'h3b, 8'h01 << b);
      acc(1, 1, 8'h1b, 8'h00);
      rdc(1, 8'h1b, 8'h01 << b);
      acc(1, 1, 8'h1b, 8'h01 << b);
      rdc(0, 8'h3b, 8'h00);
      chk({7'h0, vreq[b+1]}, 8'h00);
    end
    $display("bank test done");
  endtask : t_banks
  task automatic t_mask();
    pins[1] = ~pins[1];
    repeat (8) @(negedge clk);
    rdc(0, 8'h3b, 8'h00);
    glob = 1'b0;
    pins[0] = ~pins[0];
    repeat (8) @(negedge clk);
    rdc(0, 8'h3b, 8'h01);
    chk({7'h0, vreq[1]}, 8'h00);
    glob = 1'b1;
    ack_en = 1'b1;
    wreq(1);
    repeat (4) @(negedge clk);
    rdc(0, 8'h3b, 8'h00);
    ack_en = 1'b0;
    acc(0, 1, 8'h68, 8'h0e);
    pins[0] = ~pins[0];
    repeat (8) @(negedge clk);
    rdc(0, 8'h3b, 8'h00);
    $display("mask test done");
  endtask : t_mask
  task automatic t_ext0();
    acc(0, 1, 8'h3d, 8'h01);
    for (int m = 1; m < 4; m++) begin
      acc(0, 1, 8'h69, 8'(m));
      acc(0, 1, 8'h3c, 8'h01);
      ext0 = 1'b0;
      repeat (8) @(negedge clk);
      rdc(0, 8'h3c, {7'h0, m != 3});
      chk({7'h0, vreq[0]}, {7'h0, m != 3});
      acc(0, 1, 8'h3c, 8'h01);
      ext0 = 1'b1;
      repeat (8) @(negedge clk);
      rdc(0, 8'h3c, {7'h0, m != 2});
    end
    acc(0, 1, 8'h69, 8'h00);
    ext0 = 1'b0;
    repeat (8) @(negedge clk);
    rdc(0, 8'h3c, 8'h00);
    chk({7'h0, vreq[0]}, 8'h01);
    ext0 = 1'b1;
    $display("external pin test done");
  endtask : t_ext0
  // Reset for four cycles, then select any-change sense at once: the idle-high external pin
  // must not show a false edge while the synchronisers prime.
  initial begin
    rst = 1'b1;
    pins = '0;
    ext0 = 1'b1;
    glob = 1'b1;
    ack_en = 1'b0;
    dreq = '0;
    ioreq = '0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    acc(0, 1, 8'h69, 8'h01);
    repeat (6) @(negedge clk);
    rdc(0, 8'h3c, 8'h00);
    t_regs();
    t_banks();
    t_mask();
    t_ext0();
    final_report();
  end
endmodule : testbench
`default_nettype wire
